/* hw/swap_mask_xor_unit.sv */
// execution unit for nibble swap, mask tests, xor and wait-for-interrupt
`timescale 1ns/1ps
module swap_mask_xor_unit
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire logic [7:0] issue_opcode,
    input wire logic [7:0] issue_byte2,
    input wire logic [7:0] issue_byte3,
    output logic done,
    output logic [7:0] rf_raddr,
    input wire logic [7:0] rf_rdata,
    output logic rf_we,
    output logic [7:0] rf_waddr,
    output logic [7:0] rf_wdata,
    output logic [7:0] flags,
    input wire logic irq_req,
    input wire logic dma_req,
    output logic dma_grant,
    output logic halted
);
    typedef enum logic [2:0]
    {
        S_IDLE, S_SRC_PTR, S_SRC, S_DST_PTR, S_DST, S_HOLD, S_WAIT
    } phase_type;

    typedef struct packed
    {
        phase_type phase;
        logic [3:0] grp;
        logic [7:0] src;
        logic [7:0] dst;
        logic [7:0] dst_addr;
        logic [7:0] res;
        logic [3:0] cnt;
        logic [1:0] quarter;
        logic irq_pend;
        logic issue_ready;
        logic done;
        logic halted;
        logic dma_grant;
        logic [7:0] rf_raddr;
        logic rf_we;
        logic [7:0] rf_waddr;
        logic [7:0] rf_wdata;
        logic [7:0] flags;
        logic hold;
        logic aw_held;
        logic w_held;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_type;

    state_type st;
    state_type next_st;

    // -----------------------------------------------------------
    // decode of the offered instruction
    // -----------------------------------------------------------
    logic [3:0] op_grp;
    logic [3:0] op_mode;
    logic op_known;
    logic op_short;
    logic op_src_ind;
    logic take;
    logic finish;
    logic wr_fire;
    logic flags_wr;
    logic [7:0] aw_word;
    logic [7:0] ar_word;
    logic [7:0] alu_res;
    logic wait_exit;

    // unknown opcodes are never taken, yet issue_ready stays high, so the decoder sees them accepted and dropped
    assign op_grp = issue_opcode[7:4];
    assign op_mode = issue_opcode[3:0];
    assign op_known = issue_opcode == swap_mask_pkg::OP_WAIT_INT
        || issue_opcode == swap_mask_pkg::OP_SWAP_R
        || issue_opcode == swap_mask_pkg::OP_SWAP_PTR
        || ((op_grp == swap_mask_pkg::GRP_CMASK_TEST
        || op_grp == swap_mask_pkg::GRP_MASK_TEST
        || op_grp == swap_mask_pkg::GRP_XOR)
        && op_mode >= swap_mask_pkg::MODE_WORK
        && op_mode <= swap_mask_pkg::MODE_REG_IMM);
    assign op_short = op_grp == swap_mask_pkg::GRP_SWAP
        || op_mode == swap_mask_pkg::MODE_WORK;
    assign op_src_ind = op_mode == swap_mask_pkg::MODE_WORK_IND
        || op_mode == swap_mask_pkg::MODE_REG_IND;
    assign take = issue_valid && st.issue_ready && op_known;
    assign finish = st.phase == S_HOLD && st.cnt == 4'h1;
    assign wait_exit = st.phase == S_WAIT
        && st.quarter == swap_mask_pkg::WAIT_QUARTER_LAST
        && (st.irq_pend || irq_req);

    // the operation on the destination byte as it arrives
    assign alu_res = (st.grp == swap_mask_pkg::GRP_SWAP)
        ? {rf_rdata[3:0], rf_rdata[7:4]}
        : (st.grp == swap_mask_pkg::GRP_CMASK_TEST)
            ? (~rf_rdata & st.src)
        : (st.grp == swap_mask_pkg::GRP_MASK_TEST)
            ? (rf_rdata & st.src)
        : (rf_rdata ^ st.src);

    // bus decode: only the word address matters
    assign aw_word = st.aw_addr & swap_mask_pkg::WORD_MASK;
    assign ar_word = araddr & swap_mask_pkg::WORD_MASK;
    assign wr_fire = st.aw_held && st.w_held && !st.bvalid;
    assign flags_wr = wr_fire && st.w_lane0
        && aw_word == swap_mask_pkg::ADDR_FLAGS;

    // -----------------------------------------------------------
    // next state: bus slave first, then the instruction sequencer
    // -----------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.rf_we = 1'b0;
        // address and data are held apart so either may come first
        if (awvalid && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.w_data = wdata;
            next_st.w_lane0 = wstrb[0];
        end
        if (wr_fire)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = swap_mask_pkg::RESP_OKAY;
            if (aw_word == swap_mask_pkg::ADDR_CTRL && st.w_lane0)
                next_st.hold = st.w_data[swap_mask_pkg::CTRL_HOLD];
            else if (flags_wr)
                next_st.flags = st.w_data[7:0];
            else if (aw_word != swap_mask_pkg::ADDR_CTRL
                && aw_word != swap_mask_pkg::ADDR_STATUS
                && aw_word != swap_mask_pkg::ADDR_FLAGS)
                next_st.bresp = swap_mask_pkg::RESP_SLVERR;
        end
        else if (st.bvalid && bready)
            next_st.bvalid = 1'b0;
        // reads answer one cycle after the address is taken
        if (arvalid && st.arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = swap_mask_pkg::RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            case (ar_word)
                swap_mask_pkg::ADDR_CTRL:
                    next_st.rdata[swap_mask_pkg::CTRL_HOLD] = st.hold;
                swap_mask_pkg::ADDR_STATUS:
                begin
                    next_st.rdata[swap_mask_pkg::STATUS_BUSY] =
                        st.phase != S_IDLE;
                    next_st.rdata[swap_mask_pkg::STATUS_WAIT] = st.halted;
                end
                swap_mask_pkg::ADDR_FLAGS:
                    next_st.rdata[7:0] = st.flags;
                default:
                    next_st.rresp = swap_mask_pkg::RESP_SLVERR;
            endcase
        end
        else if (st.rvalid && rready)
            next_st.rvalid = 1'b0;
        // every fetch and execute state burns one cycle of the budget
        if (st.phase != S_IDLE && st.phase != S_WAIT)
            next_st.cnt = st.cnt - 4'h1;
        case (st.phase)
            S_IDLE:
            begin
                if (take)
                begin
                    next_st.grp = op_grp;
                    next_st.cnt = op_short
                        ? swap_mask_pkg::CYC_SHORT - 4'h1
                        : swap_mask_pkg::CYC_LONG - 4'h1;
                    // the take cycle is the first of four, so the
                    // exit lands on a whole multiple of four cycles
                    next_st.quarter = swap_mask_pkg::WAIT_QUARTER_FIRST;
                    next_st.irq_pend = 1'b0;
                    if (issue_opcode == swap_mask_pkg::OP_WAIT_INT)
                        next_st.phase = S_WAIT;
                    else if (op_grp == swap_mask_pkg::GRP_SWAP)
                    begin
                        next_st.dst_addr = issue_byte2;
                        next_st.rf_raddr = issue_byte2;
                        next_st.phase =
                            (issue_opcode == swap_mask_pkg::OP_SWAP_PTR)
                            ? S_DST_PTR : S_DST;
                    end
                    else
                    begin
                        if (op_mode == swap_mask_pkg::MODE_WORK
                            || op_mode == swap_mask_pkg::MODE_WORK_IND)
                        begin
                            next_st.dst_addr = {swap_mask_pkg::WORK_PREFIX,
                                issue_byte2[7:4]};
                            next_st.rf_raddr = {swap_mask_pkg::WORK_PREFIX,
                                issue_byte2[3:0]};
                        end
                        else if (op_mode == swap_mask_pkg::MODE_REG_IMM)
                        begin
                            next_st.dst_addr = issue_byte2;
                            next_st.rf_raddr = issue_byte2;
                            next_st.src = issue_byte3;
                        end
                        else
                        begin
                            next_st.dst_addr = issue_byte3;
                            next_st.rf_raddr = issue_byte2;
                        end
                        next_st.phase =
                            (op_mode == swap_mask_pkg::MODE_REG_IMM) ? S_DST
                            : op_src_ind ? S_SRC_PTR : S_SRC;
                    end
                end
            end
            S_SRC_PTR:
            begin
                next_st.rf_raddr = rf_rdata;
                next_st.phase = S_SRC;
            end
            S_SRC:
            begin
                next_st.src = rf_rdata;
                next_st.rf_raddr = st.dst_addr;
                next_st.phase = S_DST;
            end
            S_DST_PTR:
            begin
                next_st.dst_addr = rf_rdata;
                next_st.rf_raddr = rf_rdata;
                next_st.phase = S_DST;
            end
            S_DST:
            begin
                next_st.dst = rf_rdata;
                next_st.res = alu_res;
                next_st.phase = S_HOLD;
            end
            S_HOLD:
            begin
                // results land together at the end of the budget;
                // a bus write to flags in that cycle loses Z, S and, except after swap, V
                if (finish)
                begin
                    next_st.done = 1'b1;
                    next_st.phase = S_IDLE;
                    next_st.flags[swap_mask_pkg::FLAG_Z] =
                        st.res == 8'h00;
                    next_st.flags[swap_mask_pkg::FLAG_S] =
                        st.res[swap_mask_pkg::SIGN_BIT];
                    // swap leaves C and V as they were; D, H never touched
                    if (st.grp != swap_mask_pkg::GRP_SWAP)
                        next_st.flags[swap_mask_pkg::FLAG_V] = 1'b0;
                    if (st.grp == swap_mask_pkg::GRP_SWAP
                        || st.grp == swap_mask_pkg::GRP_XOR)
                    begin
                        next_st.rf_we = 1'b1;
                        next_st.rf_waddr = st.dst_addr;
                        next_st.rf_wdata = st.res;
                    end
                end
            end
            S_WAIT:
            begin
                // leave only on a four-cycle boundary, flags untouched
                next_st.quarter = st.quarter + 2'h1;
                next_st.irq_pend = st.irq_pend || irq_req;
                if (wait_exit)
                begin
                    next_st.done = 1'b1;
                    next_st.irq_pend = 1'b0;
                    next_st.phase = S_IDLE;
                end
            end
            default:
                next_st.phase = S_IDLE;
        endcase
        // registered handshakes derived from the state being entered
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
        next_st.halted = next_st.phase == S_WAIT;
        next_st.dma_grant = next_st.phase == S_WAIT && dma_req;
        next_st.issue_ready = next_st.phase == S_IDLE && !next_st.hold;
    end

    // state register, synchronous reset to all zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= next_st;
    end

    // outputs straight from the state register
    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign issue_ready = st.issue_ready;
    assign done = st.done;
    assign rf_raddr = st.rf_raddr;
    assign rf_we = st.rf_we;
    assign rf_waddr = st.rf_waddr;
    assign rf_wdata = st.rf_wdata;
    assign flags = st.flags;
    assign dma_grant = st.dma_grant;
    assign halted = st.halted;

    // -----------------------------------------------------------
    // checks
    // -----------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_take(logic [7:0] op);
        issue_valid && issue_ready && issue_opcode == op;
    endsequence
    sequence s_four;
        !done [*3] ##1 done;
    endsequence
    sequence s_six;
        !done [*5] ##1 done;
    endsequence

    a_swap_result: assert property (
        finish && st.grp == swap_mask_pkg::GRP_SWAP
        |=> rf_we && rf_wdata == {$past(st.dst[3:0]), $past(st.dst[7:4])}
        && flags[swap_mask_pkg::FLAG_Z] == (rf_wdata == 8'h00))
        else $error("swap result or zero flag wrong");
    a_swap_timing: assert property (
        s_take(swap_mask_pkg::OP_SWAP_PTR) |=> s_four)
        else $error("swap not four cycles");
    a_swap_keep_dh: assert property (finish && !flags_wr
        && st.grp == swap_mask_pkg::GRP_SWAP
        |=> $stable(flags[swap_mask_pkg::FLAG_D])
        && $stable(flags[swap_mask_pkg::FLAG_H]))
        else $error("swap changed D or H");
    a_cmask_value: assert property (
        finish && st.grp == swap_mask_pkg::GRP_CMASK_TEST
        |=> !rf_we && flags[swap_mask_pkg::FLAG_Z]
        == ((~$past(st.dst) & $past(st.src)) == 8'h00))
        else $error("complement test value wrong");
    a_cmask_flags: assert property (finish && !flags_wr
        && st.grp == swap_mask_pkg::GRP_CMASK_TEST
        |=> !flags[swap_mask_pkg::FLAG_V]
        && $stable(flags[swap_mask_pkg::FLAG_C]))
        else $error("complement test flags wrong");
    a_cmask_timing: assert property (
        s_take({swap_mask_pkg::GRP_CMASK_TEST, swap_mask_pkg::MODE_REG_IMM})
        |=> s_six)
        else $error("complement test not six cycles");
    a_mask_value: assert property (
        finish && st.grp == swap_mask_pkg::GRP_MASK_TEST
        |=> !rf_we && !flags[swap_mask_pkg::FLAG_V]
        && flags[swap_mask_pkg::FLAG_Z]
        == (($past(st.dst) & $past(st.src)) == 8'h00))
        else $error("mask test wrong");
    a_mask_timing: assert property (
        s_take({swap_mask_pkg::GRP_MASK_TEST, swap_mask_pkg::MODE_WORK})
        |=> s_four)
        else $error("mask test not four cycles");
    a_wait_halt: assert property (halted && dma_req && !st.irq_pend
        && !irq_req |=> halted && dma_grant && !done)
        else $error("wait state left or dma refused");
    a_wait_wake: assert property (halted && irq_req |-> ##[1:4] done)
        else $error("interrupt did not end wait");
    a_wait_flags: assert property (
        halted && !flags_wr |=> $stable(flags))
        else $error("wait changed flags");
    a_xor_store: assert property (
        finish && st.grp == swap_mask_pkg::GRP_XOR
        |=> rf_we && rf_wdata == ($past(st.dst) ^ $past(st.src))
        && rf_waddr == $past(st.dst_addr))
        else $error("xor store wrong");
    a_xor_flags: assert property (
        finish && st.grp == swap_mask_pkg::GRP_XOR
        |=> !flags[swap_mask_pkg::FLAG_V]
        && flags[swap_mask_pkg::FLAG_S] == rf_wdata[swap_mask_pkg::SIGN_BIT])
        else $error("xor flags wrong");
    a_imm_order: assert property (s_take({swap_mask_pkg::GRP_XOR,
        swap_mask_pkg::MODE_REG_IMM})
        |=> st.src == $past(issue_byte3) && st.dst_addr == $past(issue_byte2))
        else $error("immediate form byte order wrong");
endmodule

/* hw/swap_mask_pkg.sv */
// constants for the nibble swap, mask test, xor and wait unit
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package swap_mask_pkg;
    // opcodes: high nibble picks the operation, low nibble the mode
    localparam logic [7:0] OP_SWAP_R = 8'hf0;
    localparam logic [7:0] OP_SWAP_PTR = 8'hf1;
    localparam logic [7:0] OP_WAIT_INT = 8'h3f;
    localparam logic [3:0] GRP_SWAP = 4'hf;
    localparam logic [3:0] GRP_CMASK_TEST = 4'h6;
    localparam logic [3:0] GRP_MASK_TEST = 4'h7;
    localparam logic [3:0] GRP_XOR = 4'hb;
    localparam logic [3:0] MODE_WORK = 4'h2;
    localparam logic [3:0] MODE_WORK_IND = 4'h3;
    localparam logic [3:0] MODE_REG = 4'h4;
    localparam logic [3:0] MODE_REG_IND = 4'h5;
    localparam logic [3:0] MODE_REG_IMM = 4'h6;
    // working register r<n> lives at register address {prefix, n}
    localparam logic [3:0] WORK_PREFIX = 4'hc;
    // instruction lengths in clock cycles
    localparam logic [3:0] CYC_SHORT = 4'h4;
    localparam logic [3:0] CYC_LONG = 4'h6;
    localparam logic [1:0] WAIT_QUARTER_FIRST = 2'h1;
    localparam logic [1:0] WAIT_QUARTER_LAST = 2'h3;
    // flag bit positions inside the flags byte
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam int SIGN_BIT = 7;
    // register map on the AXI4-Lite slave
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] WORD_MASK = 8'hfc;
    localparam int CTRL_HOLD = 0;
    localparam int STATUS_BUSY = 8;
    localparam int STATUS_WAIT = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* tb/tb.sv */
// self-checking bench for the swap, mask test, xor and wait unit
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // stimulus, observed outputs, register file
    // ----------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, issue_valid = 1'b0, irq_req = 1'b0, dma_req = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [7:0] issue_opcode = 8'h00, issue_byte2 = 8'h00, issue_byte3 = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, issue_ready, done;
    logic rf_we, dma_grant, halted;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] rf_raddr, rf_waddr, rf_wdata, flags, rf_rdata;
    logic [7:0] mem [256];
    logic [7:0] exp_flags;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;

    always #5 aclk = ~aclk;
    // register file read is combinational, as the unit expects
    assign rf_rdata = mem[rf_raddr];
    always @(posedge aclk)
        if (rf_we === 1'b1) mem[rf_waddr] <= rf_wdata;
    // free-running edge count, so waits inside bus tasks need no guessing
    always @(posedge aclk)
        cyc <= cyc + 1;

    swap_mask_xor_unit uut
    (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .issue_valid(issue_valid), .issue_ready(issue_ready),
        .issue_opcode(issue_opcode), .issue_byte2(issue_byte2),
        .issue_byte3(issue_byte3), .done(done), .rf_raddr(rf_raddr),
        .rf_rdata(rf_rdata), .rf_we(rf_we), .rf_waddr(rf_waddr),
        .rf_wdata(rf_wdata), .flags(flags), .irq_req(irq_req),
        .dma_req(dma_req), .dma_grant(dma_grant), .halted(halted)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // both items offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er);
        bit ad;
        bit wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (awready === 1'b1 && !ad) awvalid <= 1'b0;
            if (awready === 1'b1) ad = 1;
            if (wready === 1'b1 && !wd) wvalid <= 1'b0;
            if (wready === 1'b1) wd = 1;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", bresp, er);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    // issue one instruction; n counts edges from take to done
    task automatic run(input logic [7:0] op, b2, b3, output int n,
        output logic we, output logic [7:0] fl);
        @(posedge aclk);
        issue_valid <= 1'b1;
        issue_opcode <= op;
        issue_byte2 <= b2;
        issue_byte3 <= b3;
        do @(posedge aclk); while (issue_ready !== 1'b1);
        issue_valid <= 1'b0;
        n = 0;
        we = 1'b0;
        do
        begin
            @(posedge aclk);
            n++;
            we = we | (rf_we === 1'b1);
        end
        while (done !== 1'b1);
        fl = flags;
        @(posedge aclk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_bus;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(swap_mask_pkg::ADDR_FLAGS, 8'h9c, swap_mask_pkg::RESP_OKAY);
        axi_rd(swap_mask_pkg::ADDR_FLAGS, d, r);
        chk("flags_rd", d, 32'h9c);
        chk("flags_port", flags, 8'h9c);
        axi_rd(8'h0c, d, r);
        chk("unmapped_resp", r, swap_mask_pkg::RESP_SLVERR);
        chk("unmapped_data", d, 32'h0);
        axi_wr(8'h10, 8'h55, swap_mask_pkg::RESP_SLVERR);
        // hold keeps the decoder from issuing
        axi_wr(swap_mask_pkg::ADDR_CTRL, 8'h01, swap_mask_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("held_ready", issue_ready, 1'b0);
        axi_wr(swap_mask_pkg::ADDR_CTRL, 8'h00, swap_mask_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("free_ready", issue_ready, 1'b1);
        exp_flags = 8'h9c;
    endtask

    task automatic t_swap;
        int n;
        logic we;
        logic [7:0] fl;
        mem[8'h10] = 8'h3e;
        run(8'hf0, 8'h10, 8'h00, n, we, fl);
        exp_flags = {exp_flags[7], 1'b0, 1'b1, exp_flags[4:0]};
        chk("swap_cyc", n, 4);
        chk("swap_flags", fl, exp_flags);
        chk("swap_res", mem[8'h10], 8'he3);
        mem[8'h02] = 8'h03;
        mem[8'h03] = 8'ha4;
        run(8'hf1, 8'h02, 8'h00, n, we, fl);
        exp_flags = {exp_flags[7], 2'b00, exp_flags[4:0]};
        chk("swap_ind_cyc", n, 4);
        chk("swap_ind_flags", fl, exp_flags);
        chk("swap_ind_res", mem[8'h03], 8'h4a);
        chk("swap_ptr", mem[8'h02], 8'h03);
    endtask

    // every opcode of the complement test, mask test and xor groups
    task automatic t_alu;
        logic [7:0] dv, sv, r, b2, b3, da, fl;
        logic [3:0] g, m;
        logic we;
        int n;
        logic [7:0] sets [4] = '{8'hc7, 8'h02, 8'h2b, 8'hd4};
        for (int gi = 0; gi < 3; gi++)
            for (int mi = 2; mi < 7; mi++)
                for (int s = 0; s < 2; s++)
                begin
                    g = (gi == 0) ? 4'h6 : (gi == 1) ? 4'h7 : 4'hb;
                    m = 4'(mi);
                    dv = sets[2 * s];
                    sv = sets[2 * s + 1];
                    mem[8'hc0] = dv;
                    mem[8'h40] = dv;
                    mem[8'h30] = sv;
                    mem[8'h31] = sv;
                    mem[8'h32] = 8'h31;
                    mem[8'hc1] = (mi == 2) ? sv : 8'h30;
                    da = (mi < 4) ? 8'hc0 : 8'h40;
                    b2 = (mi < 4) ? 8'h01 : (mi == 4) ? 8'h31 :
                        (mi == 5) ? 8'h32 : 8'h40;
                    b3 = (mi == 6) ? sv : 8'h40;
                    r = (gi == 0) ? (~dv & sv)
                        : (gi == 1) ? (dv & sv) : dv ^ sv;
                    run({g, m}, b2, b3, n, we, fl);
                    exp_flags = {exp_flags[7], r == 8'h00, r[7], 1'b0,
                        exp_flags[3:0]};
                    chk("cycles", n, (mi == 2) ? 4 : 6);
                    chk("flags", fl, exp_flags);
                    chk("rf_we", we, gi == 2);
                    chk("dst", mem[da], (gi == 2) ? r : dv);
                end
    endtask

    task automatic t_wait;
        int k;
        int j;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        issue_valid <= 1'b1;
        issue_opcode <= 8'h3f;
        do @(posedge aclk); while (issue_ready !== 1'b1);
        issue_valid <= 1'b0;
        dma_req <= 1'b1;
        k = cyc;
        repeat (10)
        begin
            @(posedge aclk);
            chk("wait_done", done, 1'b0);
        end
        chk("halted", halted, 1'b1);
        chk("dma_grant", dma_grant, 1'b1);
        // status shows busy and waiting while halted
        axi_rd(swap_mask_pkg::ADDR_STATUS, d, r);
        chk("wait_status", d, 32'h0000_0300);
        chk("wait_status_resp", r, swap_mask_pkg::RESP_OKAY);
        irq_req <= 1'b1;
        j = 0;
        do
        begin
            @(posedge aclk);
            j++;
        end
        while (done !== 1'b1);
        irq_req <= 1'b0;
        dma_req <= 1'b0;
        // the first counted edge is the one that first sees the request
        chk("wake_time", j >= 2 && j <= 5, 1'b1);
        chk("wait_align", (cyc - k) % 4, 0);
        chk("wait_flags", flags, exp_flags);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_bus;
        t_swap;
        t_alu;
        t_wait;
        test_done;
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        #200000;
        err_count++;
        test_done;
    end
endmodule
